// ---- core/i2c_target_pkg.sv ----
// Constants, state codes and helpers shared by the block-read target and its buffer
package i2c_target_pkg;
    localparam int BYTE_W = 8;
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL_CNT = 2'h2;
    localparam logic [1:0] BUF_ONE = 2'h1;
    localparam logic [1:0] BUF_EMPTY_CNT = 2'h0;
    // Bus address of this target; value is arbitrary
    localparam logic [6:0] TARGET_ADDR = 7'h2A;
    localparam logic [7:0] CMD_BLOCK_READ = 8'hA1;
    localparam logic [7:0] CMD_SET_POINTER = 8'hB0;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_ONE = 3'h1;
    localparam logic [1:0] SYNC_RESET = 2'h3;

    typedef enum logic [10:0] {
        ST_IDLE     = 11'h001,
        ST_ADDR     = 11'h002,
        ST_ADDR_ACK = 11'h004,
        ST_CMD      = 11'h008,
        ST_CMD_ACK  = 11'h010,
        ST_DATA_RX  = 11'h020,
        ST_DATA_ACK = 11'h040,
        ST_LOAD     = 11'h080,
        ST_TX       = 11'h100,
        ST_TX_ACK   = 11'h200,
        ST_IGNORE   = 11'h400
    } state_t;

    function automatic logic cmd_known(input logic [7:0] code);
        cmd_known = (code == CMD_BLOCK_READ) || (code == CMD_SET_POINTER);
    endfunction
endpackage

// ---- core/byte_buffer.sv ----
// Two-entry byte buffer with valid/ready on both sides and a flush
`timescale 1ns/10ps
`default_nettype none
module byte_buffer (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic flush,
    input wire logic [i2c_target_pkg::BYTE_W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [i2c_target_pkg::BYTE_W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    import i2c_target_pkg::*;

    logic [BYTE_W-1:0] mem [BUF_DEPTH];
    logic wr_q;
    logic rd_q;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic push;
    logic pop;
    logic in_ready_q;
    logic out_valid_q;

    assign push = in_valid && in_ready_q;
    assign pop = out_valid_q && out_ready;
    assign in_ready = in_ready_q;
    assign out_valid = out_valid_q;
    assign out_data = mem[rd_q];

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + BUF_ONE;
        end else if (pop && !push) begin
            cnt_d = cnt_q - BUF_ONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Flags are registered from the next count so both sides see honest full/empty
    always_ff @(posedge sys_clk) begin
        if (sys_rst || flush) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= BUF_EMPTY_CNT;
            in_ready_q <= 1'b1;
            out_valid_q <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_d;
            in_ready_q <= (cnt_d != BUF_FULL_CNT);
            out_valid_q <= (cnt_d != BUF_EMPTY_CNT);
        end
    end
endmodule
`default_nettype wire

// ---- core/i2c_block_read_target.sv ----
// Two-wire bus target that sets the register pointer and serves block reads
`timescale 1ns/10ps
`default_nettype none
module i2c_block_read_target (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [i2c_target_pkg::BYTE_W-1:0] rd_addr,
    input wire logic [i2c_target_pkg::BYTE_W-1:0] rd_data,
    input wire logic rd_valid,
    output logic rd_ready,
    output logic [i2c_target_pkg::BYTE_W-1:0] reg_ptr,
    output logic [i2c_target_pkg::BYTE_W-1:0] bytes_left,
    output logic busy
);
    import i2c_target_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and bus event detection

    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] prev_q;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // Bit 1 is the clock line, bit 0 the data line; idle bus reads high
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_q <= SYNC_RESET;
            sync_q <= SYNC_RESET;
            prev_q <= SYNC_RESET;
        end else begin
            meta_q <= {scl_in, sda_in};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign scl_s = sync_q[1];
    assign sda_s = sync_q[0];
    assign scl_rise = scl_s && !prev_q[1];
    assign scl_fall = !scl_s && prev_q[1];
    assign start_det = scl_s && prev_q[1] && !sda_s && prev_q[0];
    assign stop_det = scl_s && prev_q[1] && sda_s && !prev_q[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Read data path: fetch pointer feeding the two-entry buffer

    logic flush_q;
    logic [BYTE_W-1:0] fetch_q;
    logic buf_in_ready;
    logic [BYTE_W-1:0] buf_data;
    logic buf_valid;
    logic pop;
    state_t state_q;

    assign rd_addr = fetch_q;
    assign rd_ready = buf_in_ready;
    assign pop = (state_q == ST_LOAD) && buf_valid;

    // Prefetch runs ahead of the register pointer; a flush restarts it there
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fetch_q <= PTR_RESET;
        end else if (flush_q) begin
            fetch_q <= reg_ptr;
        end else if (rd_valid && buf_in_ready) begin
            fetch_q <= fetch_q + BYTE_ONE;
        end
    end

    byte_buffer u_buf (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .flush(flush_q),
        .in_data(rd_data),
        .in_valid(rd_valid && !flush_q),
        .in_ready(buf_in_ready),
        .out_data(buf_data),
        .out_valid(buf_valid),
        .out_ready(pop)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Transfer state machine

    logic [2:0] bit_q;
    logic full_q;
    logic [BYTE_W-1:0] shift_q;
    logic [BYTE_W-1:0] cmd_q;
    logic [BYTE_W-1:0] next_byte;

    assign next_byte = {shift_q[BYTE_W-2:0], sda_s};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            bit_q <= BIT_FIRST;
            full_q <= 1'b0;
            shift_q <= PTR_RESET;
            cmd_q <= PTR_RESET;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            flush_q <= 1'b0;
            reg_ptr <= PTR_RESET;
            bytes_left <= COUNT_RESET;
        end else begin
            flush_q <= 1'b0;
            if (start_det) begin
                // Also covers the repeated start before the read address
                state_q <= ST_ADDR;
                bit_q <= BIT_FIRST;
                full_q <= 1'b0;
                sda_oe <= 1'b0;
                scl_oe <= 1'b0;
            end else if (stop_det) begin
                state_q <= ST_IDLE;
                sda_oe <= 1'b0;
                scl_oe <= 1'b0;
                full_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_ADDR, ST_CMD, ST_DATA_RX: begin
                        if (scl_rise) begin
                            shift_q <= next_byte;
                            bit_q <= bit_q + BIT_ONE;
                            full_q <= (bit_q == BIT_LAST);
                        end else if (scl_fall && full_q) begin
                            full_q <= 1'b0;
                            if (state_q == ST_ADDR) begin
                                if (shift_q[7:1] == TARGET_ADDR) begin
                                    sda_oe <= 1'b1;
                                    state_q <= ST_ADDR_ACK;
                                    flush_q <= shift_q[0];
                                end else begin
                                    state_q <= ST_IGNORE;
                                end
                            end else if (state_q == ST_CMD) begin
                                if (cmd_known(shift_q)) begin
                                    sda_oe <= 1'b1;
                                    cmd_q <= shift_q;
                                    state_q <= ST_CMD_ACK;
                                end else begin
                                    state_q <= ST_IGNORE;
                                end
                            end else begin
                                sda_oe <= 1'b1;
                                state_q <= ST_DATA_ACK;
                                if (cmd_q == CMD_SET_POINTER) begin
                                    reg_ptr <= shift_q;
                                end else begin
                                    bytes_left <= shift_q;
                                end
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            bit_q <= BIT_FIRST;
                            state_q <= shift_q[0] ? ST_LOAD : ST_CMD;
                        end
                    end
                    ST_CMD_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            bit_q <= BIT_FIRST;
                            state_q <= ST_DATA_RX;
                        end
                    end
                    ST_DATA_ACK: begin
                        // Further write bytes are not acknowledged
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            state_q <= ST_IGNORE;
                        end
                    end
                    ST_LOAD: begin
                        // Clock is low here; hold it low until a byte is ready
                        if (buf_valid) begin
                            shift_q <= buf_data;
                            sda_oe <= ~buf_data[7];
                            scl_oe <= 1'b0;
                            bit_q <= BIT_FIRST;
                            full_q <= 1'b0;
                            state_q <= ST_TX;
                        end else begin
                            scl_oe <= 1'b1;
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            bit_q <= bit_q + BIT_ONE;
                            full_q <= (bit_q == BIT_LAST);
                        end else if (scl_fall) begin
                            if (full_q) begin
                                full_q <= 1'b0;
                                sda_oe <= 1'b0;
                                state_q <= ST_TX_ACK;
                            end else begin
                                shift_q <= {shift_q[BYTE_W-2:0], 1'b0};
                                sda_oe <= ~shift_q[6];
                            end
                        end
                    end
                    ST_TX_ACK: begin
                        if (scl_rise) begin
                            reg_ptr <= reg_ptr + BYTE_ONE;
                            if (bytes_left != COUNT_RESET) begin
                                bytes_left <= bytes_left - BYTE_ONE;
                            end
                            if (sda_s) begin
                                state_q <= ST_IGNORE;
                            end
                        end else if (scl_fall) begin
                            state_q <= ST_LOAD;
                        end
                    end
                    ST_IGNORE: begin
                        sda_oe <= 1'b0;
                        scl_oe <= 1'b0;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers and status

    // Open-drain: the pins only ever pull low, so the data value stays zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sda_out <= 1'b0;
            scl_out <= 1'b0;
            busy <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            scl_out <= 1'b0;
            busy <= (state_q != ST_IDLE);
        end
    end
endmodule
`default_nettype wire

// ---- dv/i2c_block_read_target_monitor.sv ----
// Checker on the block-read target's ports
`timescale 1ns/10ps
`default_nettype none
module i2c_block_read_target_monitor (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [i2c_target_pkg::BYTE_W-1:0] rd_addr,
    input wire logic [i2c_target_pkg::BYTE_W-1:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_ready,
    input wire logic [i2c_target_pkg::BYTE_W-1:0] reg_ptr,
    input wire logic [i2c_target_pkg::BYTE_W-1:0] bytes_left,
    input wire logic busy
);
    import i2c_target_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_take;
        rd_valid && rd_ready && !busy;
    endsequence
    sequence s_stop;
        $rose(sda_in) && scl_in && $past(scl_in);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_reset_quiet: assert property ($fell(sys_rst) |-> !busy && !sda_oe && !scl_oe
        && reg_ptr == 8'h00 && bytes_left == 8'h00) else $error("reset state wrong");
    a_outs_low: assert property (!sda_out && !scl_out) else $error("drive value not zero");
    a_idle_quiet: assert property (!busy |-> !sda_oe && !scl_oe)
        else $error("line driven while idle");
    // Past clock level, because a stretch release moves data and clock together
    a_sda_settle: assert property ($changed(sda_oe) |-> !$past(scl_in))
        else $error("data changed with clock high");
    a_stretch_busy: assert property (scl_oe |-> busy) else $error("stretch while idle");
    a_fetch_step: assert property (s_take |=> rd_addr == $past(rd_addr) + 8'h01)
        else $error("fetch address not stepped");
    a_addr_hold: assert property (!busy && !(rd_valid && rd_ready) |=> $stable(rd_addr))
        else $error("fetch address moved");
    a_fill_refuse: assert property (s_take [*2] |=> !rd_ready)
        else $error("buffer took a third byte");
    a_stop_idle: assert property (s_stop |-> ##[1:8] !busy) else $error("no idle after stop");
    a_start_busy: assert property ($fell(sda_in) && scl_in && $past(scl_in) |-> ##[1:8] busy)
        else $error("start not seen");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind i2c_block_read_target i2c_block_read_target_monitor u_mon (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .reg_ptr(reg_ptr), .bytes_left(bytes_left), .busy(busy)
);
`default_nettype wire

// ---- dv/i2c_ctl_model.sv ----
// Bus controller model pulling the open-drain clock and data lines
`timescale 1ns/10ps
`default_nettype none
module i2c_ctl_model (
    input wire logic sys_clk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_pull,
    output logic sda_pull
);
    initial begin
        scl_pull = 1'h0;
        sda_pull = 1'h0;
    end
    // Stretching is waited out, but bounded so a stuck target cannot hang the run
    task automatic rise_scl();
        scl_pull <= 1'h0;
        for (int k = 0; k < 4000 && scl !== 1'h1; k++) begin
            @(posedge sys_clk);
        end
    endtask
    // Five cycles low, three high; data moves two cycles after the fall
    task automatic bit_io(input logic b, output logic s);
        sda_pull <= ~b;
        repeat (3) @(posedge sys_clk);
        rise_scl();
        @(posedge sys_clk);
        s = sda;
        @(posedge sys_clk);
        scl_pull <= 1'h1;
        repeat (2) @(posedge sys_clk);
    endtask
    // Start or repeated start when stop is low, stop condition otherwise
    task automatic cond(input logic stop);
        sda_pull <= stop;
        repeat (3) @(posedge sys_clk);
        rise_scl();
        repeat (4) @(posedge sys_clk);
        sda_pull <= ~stop;
        repeat (4) @(posedge sys_clk);
        scl_pull <= ~stop;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'h1, s);
        ack = ~s;
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'h1, s);
            d = {d[6:0], s};
        end
        bit_io(last, s);
    endtask
endmodule
`default_nettype wire

// ---- dv/i2c_block_read_target_tb.sv ----
// Self-checking bench: controller model against the block-read target
`timescale 1ns/10ps
`default_nettype none
module i2c_block_read_target_tb;
    import i2c_target_pkg::*;
    logic sys_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic rd_valid = 1'h1;
    logic rnd_en = 1'h0;
    logic stall_on = 1'h0;
    logic stretch_seen = 1'h0;
    int stall_cnt = 0;
    logic [31:0] seed = 32'h0CF9DE27;
    logic [31:0] vseed = 32'h0CF9DE27;
    logic scl_pull, sda_pull, scl_out, scl_oe, sda_out, sda_oe, rd_ready, busy;
    logic [7:0] rd_addr, reg_ptr, bytes_left;
    wire logic [7:0] rd_data;
    wire logic scl_w;
    wire logic sda_w;
    int checks = 0;
    int miscompares = 0;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] reg_val(input logic [7:0] a);
        return {a[3:0], a[7:4]} ^ 8'h5A;
    endfunction
    // Pull-ups: a line is low whenever any party pulls it
    assign scl_w = ~(scl_pull | scl_oe);
    assign sda_w = ~(sda_pull | sda_oe);
    assign rd_data = reg_val(rd_addr);
    always #10 sys_clk = ~sys_clk;
    i2c_block_read_target u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .reg_ptr(reg_ptr), .bytes_left(bytes_left), .busy(busy)
    );
    i2c_ctl_model u_ctl (
        .sys_clk(sys_clk), .scl(scl_w), .sda(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull)
    );
    // Random fetch gaps; a long forced stall empties the buffer so the target must stretch
    always @(posedge sys_clk) begin
        stall_cnt <= stall_on ? stall_cnt + 1 : 0;
        if (scl_oe === 1'h1) begin
            stretch_seen <= 1'h1;
        end
        if (rnd_en) begin
            vseed <= xs(vseed);
            rd_valid <= vseed[1:0] != 2'h0 && !(stall_on && stall_cnt < 300);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr_seq(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
        input int nb, output logic [7:0] ak);
        logic [7:0] b [3];
        logic a;
        b = '{b0, b1, b2};
        ak = 8'h00;
        u_ctl.cond(1'h0);
        for (int i = 0; i < nb; i++) begin
            u_ctl.send_byte(b[i], a);
            ak[i] = a;
        end
        u_ctl.cond(1'h1);
    endtask
    task automatic block_read(input logic [7:0] p, input logic [7:0] n, input logic stall);
        logic [7:0] ak;
        logic [7:0] d;
        wr_seq({TARGET_ADDR, 1'h0}, CMD_SET_POINTER, p, 3, ak);
        check(ak, 8'h07);
        check(reg_ptr, p);
        u_ctl.cond(1'h0);
        u_ctl.send_byte({TARGET_ADDR, 1'h0}, ak[0]);
        u_ctl.send_byte(CMD_BLOCK_READ, ak[1]);
        u_ctl.send_byte(n, ak[2]);
        check(bytes_left, n);
        stall_on <= stall;
        u_ctl.cond(1'h0);
        u_ctl.send_byte({TARGET_ADDR, 1'h1}, ak[3]);
        check(ak, 8'h0F);
        if (stall) begin
            check(rd_addr, p);
        end
        for (int i = 0; i < 32'(n); i++) begin
            u_ctl.recv_byte(i == 32'(n) - 1, d);
            check(d, reg_val(p + 8'(i)));
        end
        stall_on <= 1'h0;
        if (stall) begin
            check({7'h00, stretch_seen}, 8'h01);
        end
        repeat (8) @(posedge sys_clk);
        check({7'h00, sda_oe}, 8'h00);
        u_ctl.cond(1'h1);
        check({6'h00, busy, scl_oe}, 8'h00);
        check(reg_ptr, p + n);
        check(bytes_left, 8'h00);
        $display("block read at %h of %0d bytes done", p, n);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] ak;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'h0;
        repeat (8) @(posedge sys_clk);
        check({5'h00, busy, scl_oe, sda_oe}, 8'h00);
        check({6'h00, scl_out, sda_out}, 8'h00);
        check(reg_ptr | bytes_left, 8'h00);
        check(rd_addr, 8'h02);
        check({7'h00, rd_ready}, 8'h00);
        $display("reset and prefetch test done");
        rnd_en <= 1'h1;
        wr_seq({TARGET_ADDR ^ 7'h01, 1'h0}, 8'h00, 8'h00, 1, ak);
        check(ak, 8'h00);
        wr_seq({TARGET_ADDR, 1'h0}, 8'hA0, 8'h00, 2, ak);
        check(ak, 8'h01);
        $display("refusal test done");
        block_read(8'hFE, 8'h03, 1'h0);
        block_read(8'h40, 8'h01, 1'h1);
        block_read(8'h10, 8'h08, 1'h0);
        for (int k = 0; k < 5; k++) begin
            seed = xs(seed);
            block_read(seed[7:0], {5'h00, seed[10:8]} + 8'h01, 1'h0);
        end
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        miscompares++;
        complete_run();
    end
endmodule
`default_nettype wire
